// ==== sgcr_regs.sv ====
// Global control registers: sniff mode, host port, storm limit, MIB ctl.
// Assumes a synchronous byte register port, read data one cycle later.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module sgcr_regs
    import sgcr_pkg::*;
#(
    parameter int unsigned NUM_PORTS   = SGCR_NUM_PORTS,
    parameter int unsigned PERIOD_100  = SGCR_PERIOD_100_CYC,
    parameter int unsigned PERIOD_10   = SGCR_PERIOD_10_CYC
) (
    // Clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   nrst_i,
    // Register port
    input  wire logic [7:0]             addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    // Mirror matching
    input  wire logic                   sniff_src_hit_i,
    input  wire logic                   sniff_dst_hit_i,
    output logic                        sniff_mirror_o,
    // Host port interface
    output sgcr_host_cfg_t              host_cfg_o,
    // Storm metering per port
    input  wire logic [NUM_PORTS-1:0]   bcast_block_i,
    input  wire logic [NUM_PORTS-1:0]   bcast_sof_i,
    output logic      [NUM_PORTS-1:0]   storm_drop_o,
    // Statistics counters
    output sgcr_mib_ctl_t               mib_ctl_o
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic                   sniff_and_q;
    logic [7:0]             host_storm_q;
    logic [7:0]             storm_low_q;
    logic                   flush_q;
    logic                   freeze_q;
    logic [NUM_PORTS-1:0]   port_en_q;
    logic [7:0]             rdata_q;
    logic                   mirror_q;
    sgcr_host_cfg_t         host_cfg_q;
    sgcr_mib_ctl_t          mib_q;
    logic [2:0]             flush_cnt_q;
    logic [31:0]            period_cnt_q;
    logic                   period_start_q;
    logic [SGCR_LIMIT_W-1:0] limit;
    logic                   wr_flush;

    assign limit    = {host_storm_q[2:0], storm_low_q};
    assign wr_flush = wr_i && hit(addr_i, SGCR_OFF_FLUSH);

    // Register writes, one block per register; the flush register has two
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sniff_and_q <= 1'b0;
        end else if (wr_i && hit(addr_i, SGCR_OFF_SNIFF)) begin
            sniff_and_q <= wdata_i[SGCR_BIT_SNIFF];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            host_storm_q <= SGCR_RST_HOST_STORM;
        end else if (wr_i && hit(addr_i, SGCR_OFF_HOST_STORM)) begin
            host_storm_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            storm_low_q <= SGCR_RST_STORM_LOW;
        end else if (wr_i && hit(addr_i, SGCR_OFF_STORM_LOW)) begin
            storm_low_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            freeze_q  <= 1'b0;
            port_en_q <= '0;
        end else if (wr_flush) begin
            freeze_q  <= wdata_i[SGCR_BIT_FREEZE];
            port_en_q <= wdata_i[NUM_PORTS-1:0];
        end
    end

    // Flush runs one cycle per port; a new 1 written restarts it
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            flush_q     <= 1'b0;
            flush_cnt_q <= '0;
        end else if (wr_flush && wdata_i[SGCR_BIT_FLUSH]) begin
            flush_q     <= 1'b1;
            flush_cnt_q <= 3'(SGCR_FLUSH_CYC - 1);
        end else if (flush_q) begin
            if (flush_cnt_q == '0) begin
                flush_q <= 1'b0;
            end else begin
                flush_cnt_q <= flush_cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            mib_q <= '0;
        end else begin
            mib_q.flush  <= flush_q  ? port_en_q : '0;
            mib_q.freeze <= freeze_q ? port_en_q : '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            host_cfg_q <= '0;
        end else begin
            host_cfg_q.back_pressure    <= host_storm_q[SGCR_BIT_BP];
            host_cfg_q.half_duplex      <= host_storm_q[SGCR_BIT_HALF];
            host_cfg_q.flow_control     <= host_storm_q[SGCR_BIT_FC];
            host_cfg_q.speed_10         <= host_storm_q[SGCR_BIT_SPD10];
            host_cfg_q.null_vid_replace <= host_storm_q[SGCR_BIT_NULLVID];
        end
    end

    // Mirror decision
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            mirror_q <= 1'b0;
        end else if (sniff_and_q) begin
            mirror_q <= sniff_src_hit_i && sniff_dst_hit_i;
        end else begin
            mirror_q <= sniff_src_hit_i || sniff_dst_hit_i;
        end
    end

    // Storm period timer; speed follows the host port setting
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            period_cnt_q   <= '0;
            period_start_q <= 1'b0;
        end else if (period_cnt_q >= (host_storm_q[SGCR_BIT_SPD10] ?
                     PERIOD_10 - 1 : PERIOD_100 - 1)) begin
            period_cnt_q   <= '0;
            period_start_q <= 1'b1;
        end else begin
            period_cnt_q   <= period_cnt_q + 1'b1;
            period_start_q <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_storm
            sgcr_storm_port #(
                .LIMIT_W (SGCR_LIMIT_W)
            ) u_storm (
                .clk_sys_i      (clk_sys_i),
                .nrst_i         (nrst_i),
                .period_start_i (period_start_q),
                .limit_i        (limit),
                .bcast_block_i  (bcast_block_i[g]),
                .bcast_sof_i    (bcast_sof_i[g]),
                .drop_o         (storm_drop_o[g])
            );
        end
    endgenerate

    // Read data, zero for unmapped addresses
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            case (addr_i)
                SGCR_OFF_SNIFF:      rdata_q <= {7'h00, sniff_and_q};
                SGCR_OFF_HOST_STORM: rdata_q <= host_storm_q;
                SGCR_OFF_STORM_LOW:  rdata_q <= storm_low_q;
                SGCR_OFF_FLUSH:      rdata_q <= {flush_q, freeze_q, 1'b0, port_en_q};
                default:             rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o        = rdata_q;
    assign sniff_mirror_o = mirror_q;
    assign host_cfg_o     = host_cfg_q;
    assign mib_ctl_o      = mib_q;

    property p_flush_done;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(flush_q) && !wr_flush |-> ##[1:5] !flush_q;
    endproperty
    a_flush_done: assert property (p_flush_done) else $error("flush stuck");

    property p_freeze;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        freeze_q |=> mib_q.freeze == port_en_q || $changed(port_en_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze mask wrong");

    property p_mirror_and;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        sniff_and_q && sniff_src_hit_i && !sniff_dst_hit_i |=> !mirror_q;
    endproperty
    a_mirror_and: assert property (p_mirror_and) else $error("and mirror");

    property p_limit_reset;
        @(posedge clk_sys_i)
        !nrst_i |=> limit == 11'h04a;
    endproperty
    a_limit_reset: assert property (p_limit_reset) else $error("limit reset");

    property p_flush_start;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        wr_flush && wdata_i[SGCR_BIT_FLUSH] |=> flush_q;
    endproperty
    a_flush_start: assert property (p_flush_start) else $error("flush not started");

    property p_flush_mask;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        flush_q |=> mib_q.flush == $past(port_en_q);
    endproperty
    a_flush_mask: assert property (p_flush_mask) else $error("flush mask wrong");

    property p_flush_idle;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !flush_q |=> mib_q.flush == '0;
    endproperty
    a_flush_idle: assert property (p_flush_idle) else $error("flush while idle");

    property p_flush_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        flush_q && flush_cnt_q == 3'h0 && !(wr_flush && wdata_i[SGCR_BIT_FLUSH]) |=> !flush_q;
    endproperty
    a_flush_clear: assert property (p_flush_clear) else $error("flush did not clear");

    property p_freeze_idle;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !freeze_q |=> mib_q.freeze == '0;
    endproperty
    a_freeze_idle: assert property (p_freeze_idle) else $error("freeze while idle");

    property p_port_en;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        wr_flush |=> port_en_q == $past(wdata_i[NUM_PORTS-1:0]);
    endproperty
    a_port_en: assert property (p_port_en) else $error("port enables wrong");

    property p_mirror_or;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !sniff_and_q && (sniff_src_hit_i || sniff_dst_hit_i) |=> mirror_q;
    endproperty
    a_mirror_or: assert property (p_mirror_or) else $error("or mirror");

    property p_rdata_idle;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !rd_i |=> rdata_q == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

    property p_flush_rsvd;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        rd_i && hit(addr_i, SGCR_OFF_FLUSH) |=> rdata_q[5] == 1'b0;
    endproperty
    a_flush_rsvd: assert property (p_flush_rsvd) else $error("reserved bit set");

    property p_bp;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        nrst_i |=> host_cfg_q.back_pressure == $past(host_storm_q[SGCR_BIT_BP]);
    endproperty
    a_bp: assert property (p_bp) else $error("back pressure wrong");

    property p_half;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        nrst_i |=> host_cfg_q.half_duplex == $past(host_storm_q[SGCR_BIT_HALF]);
    endproperty
    a_half: assert property (p_half) else $error("duplex wrong");

    property p_fc;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        nrst_i |=> host_cfg_q.flow_control == $past(host_storm_q[SGCR_BIT_FC]);
    endproperty
    a_fc: assert property (p_fc) else $error("flow control wrong");

    property p_spd;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        nrst_i |=> host_cfg_q.speed_10 == $past(host_storm_q[SGCR_BIT_SPD10]);
    endproperty
    a_spd: assert property (p_spd) else $error("speed wrong");

    property p_nvid;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        nrst_i |=> host_cfg_q.null_vid_replace == $past(host_storm_q[SGCR_BIT_NULLVID]);
    endproperty
    a_nvid: assert property (p_nvid) else $error("null id replace wrong");

    property p_limit_low;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        wr_i && hit(addr_i, SGCR_OFF_STORM_LOW) |=> limit[7:0] == $past(wdata_i);
    endproperty
    a_limit_low: assert property (p_limit_low) else $error("limit low wrong");

    property p_limit_high;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        wr_i && hit(addr_i, SGCR_OFF_HOST_STORM) |=> limit[10:8] == $past(wdata_i[2:0]);
    endproperty
    a_limit_high: assert property (p_limit_high) else $error("limit high wrong");

    // Shortest period either speed may run; a start never comes sooner
    localparam int unsigned PERIOD_MIN = (PERIOD_10 < PERIOD_100) ? PERIOD_10 : PERIOD_100;
    property p_period_min;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        period_start_q |-> $past(period_cnt_q) >= PERIOD_MIN - 1;
    endproperty
    a_period_min: assert property (p_period_min) else $error("period too short");

    property p_period_bound;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        period_cnt_q < PERIOD_10 || period_cnt_q < PERIOD_100;
    endproperty
    a_period_bound: assert property (p_period_bound) else $error("period overrun");

    property p_storm_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        period_start_q |=> storm_drop_o == '0;
    endproperty
    a_storm_clear: assert property (p_storm_clear) else $error("drop past period");

endmodule

// ==== sgcr_pkg.sv ====
// Package for the switch global control register bank.
// Assumes one 125 MHz clock and a plain byte-wide register port.
package sgcr_pkg;

    localparam int unsigned SGCR_NUM_PORTS     = 5;
    localparam int unsigned SGCR_ADDR_W        = 8;
    localparam int unsigned SGCR_DATA_W        = 8;
    localparam int unsigned SGCR_LIMIT_W       = 11;
    localparam int unsigned SGCR_BLOCK_BYTES   = 64;

    // Register offsets
    localparam logic [7:0] SGCR_OFF_SNIFF      = 8'h05;
    localparam logic [7:0] SGCR_OFF_HOST_STORM = 8'h06;
    localparam logic [7:0] SGCR_OFF_STORM_LOW  = 8'h07;
    localparam logic [7:0] SGCR_OFF_FLUSH      = 8'h08;

    // Field positions
    localparam int unsigned SGCR_BIT_SNIFF     = 0;
    localparam int unsigned SGCR_BIT_BP        = 7;
    localparam int unsigned SGCR_BIT_HALF      = 6;
    localparam int unsigned SGCR_BIT_FC        = 5;
    localparam int unsigned SGCR_BIT_SPD10     = 4;
    localparam int unsigned SGCR_BIT_NULLVID   = 3;
    localparam int unsigned SGCR_BIT_FLUSH     = 7;
    localparam int unsigned SGCR_BIT_FREEZE    = 6;

    // Reset values
    localparam logic [7:0] SGCR_RST_HOST_STORM = 8'h00;
    localparam logic [7:0] SGCR_RST_STORM_LOW  = 8'h4a;
    localparam logic [7:0] SGCR_RST_FLUSH      = 8'h00;

    // Storm period in ms and cycles at 125 MHz
    localparam longint unsigned SGCR_CLK_HZ       = 125_000_000;
    localparam longint unsigned SGCR_PERIOD_100_MS = 50;
    localparam longint unsigned SGCR_PERIOD_10_MS  = 500;
    localparam int unsigned SGCR_PERIOD_100_CYC =
        int'(SGCR_PERIOD_100_MS * SGCR_CLK_HZ / 1000);
    localparam int unsigned SGCR_PERIOD_10_CYC  =
        int'(SGCR_PERIOD_10_MS * SGCR_CLK_HZ / 1000);

    // Cycles the counter clear takes, one per port
    localparam int unsigned SGCR_FLUSH_CYC     = SGCR_NUM_PORTS;

    typedef struct packed {
        logic       back_pressure;
        logic       half_duplex;
        logic       flow_control;
        logic       speed_10;
        logic       null_vid_replace;
    } sgcr_host_cfg_t;

    typedef struct packed {
        logic [SGCR_NUM_PORTS-1:0] flush;
        logic [SGCR_NUM_PORTS-1:0] freeze;
    } sgcr_mib_ctl_t;

    typedef enum logic [1:0] {
        SGCR_FL_IDLE,
        SGCR_FL_RUN
    } sgcr_flush_state_t;

endpackage

// ==== sgcr_storm_port.sv ====
// Broadcast storm meter for one input port.
// Assumes period_start_i pulses once per measurement period.
`timescale 1ns/1ps
module sgcr_storm_port
    import sgcr_pkg::*;
#(
    parameter int unsigned LIMIT_W = SGCR_LIMIT_W
) (
    // Clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               nrst_i,
    // Control
    input  wire logic               period_start_i,
    input  wire logic [LIMIT_W-1:0] limit_i,
    // Traffic
    input  wire logic               bcast_block_i,
    input  wire logic               bcast_sof_i,
    output logic                    drop_o
);

    logic [LIMIT_W-1:0] count_q;
    logic               drop_q;

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            count_q <= '0;
        end else if (period_start_i) begin
            count_q <= '0;
        // Saturates at the limit; a limit lowered mid-period cannot wrap it
        end else if (bcast_block_i && !drop_q && count_q < limit_i) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Drop decided at frame start, but a period start clears it at once, even mid-frame
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            drop_q <= 1'b0;
        end else if (period_start_i) begin
            drop_q <= 1'b0;
        end else if (bcast_sof_i) begin
            drop_q <= (count_q >= limit_i);
        end
    end

    assign drop_o = drop_q;

endmodule

// ==== tb.sv ====
// Self-checking bench for the global control register bank.
// Assumes short storm periods passed in through the top's parameters.
`timescale 1ns/1ps
module tb;
    import sgcr_pkg::*;

    localparam int unsigned PER = 100;

    typedef struct {
        logic [7:0] a;
        logic [7:0] wd;
        logic [7:0] rb;
        logic [4:0] hc;
    } sgcr_row_t;

    logic           clk_sys_i = 1'b0;
    logic           nrst_i    = 1'b0;
    logic [7:0]     addr_i    = 8'h00;
    logic [7:0]     wdata_i   = 8'h00;
    logic           wr_i      = 1'b0;
    logic           rd_i      = 1'b0;
    logic [7:0]     rdata_o;
    logic           src_hit   = 1'b0;
    logic           dst_hit   = 1'b0;
    logic           sniff_mirror_o;
    sgcr_host_cfg_t host_cfg_o;
    logic [4:0]     blk       = 5'h00;
    logic [4:0]     sof       = 5'h00;
    logic [4:0]     storm_drop_o;
    sgcr_mib_ctl_t  mib_ctl_o;
    int             n_errors  = 0;
    int             cmp_count = 0;
    sgcr_row_t      rows[9];
    logic [7:0]     rv;
    int             n;

    always #4 clk_sys_i = ~clk_sys_i;

    sgcr_regs #(.PERIOD_100(PER), .PERIOD_10(10 * PER)) dut_u (
        .clk_sys_i       (clk_sys_i),
        .nrst_i          (nrst_i),
        .addr_i          (addr_i),
        .wdata_i         (wdata_i),
        .wr_i            (wr_i),
        .rd_i            (rd_i),
        .rdata_o         (rdata_o),
        .sniff_src_hit_i (src_hit),
        .sniff_dst_hit_i (dst_hit),
        .sniff_mirror_o  (sniff_mirror_o),
        .host_cfg_o      (host_cfg_o),
        .bcast_block_i   (blk),
        .bcast_sof_i     (sof),
        .storm_drop_o    (storm_drop_o),
        .mib_ctl_o       (mib_ctl_o)
    );

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask

    // Two blocks then a frame start on port 1; ends just after the drop decision
    task automatic burst();
        @(posedge clk_sys_i);
        blk <= 5'h01;
        repeat (2) @(posedge clk_sys_i);
        blk <= 5'h00;
        sof <= 5'h01;
        @(posedge clk_sys_i);
        sof <= 5'h00;
        #1;
    endtask

    task automatic chk_reset();
        rd(8'h06, rv); chk("host_reg", 8'h00, rv);
        rd(8'h07, rv); chk("storm_low", 8'h4a, rv);
        rd(8'h08, rv); chk("mib_reg", 8'h00, rv);
        rd(8'h05, rv); chk("sniff_reg", 8'h00, rv);
        chk("host_cfg", 16'h0000, host_cfg_o);
        chk("mib_ctl", 16'h0000, mib_ctl_o);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        // Reckoned at under two thousand cycles of work, with wide margin
        #(30000 * 8);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        rows = '{'{8'h06, 8'h80, 8'h80, 5'b10000},
                 '{8'h06, 8'h40, 8'h40, 5'b01000},
                 '{8'h06, 8'h20, 8'h20, 5'b00100},
                 '{8'h06, 8'h10, 8'h10, 5'b00010},
                 '{8'h06, 8'h08, 8'h08, 5'b00001},
                 '{8'h06, 8'h05, 8'h05, 5'b00000},
                 '{8'h07, 8'ha5, 8'ha5, 5'b00000},
                 '{8'h05, 8'h01, 8'h01, 5'b00000},
                 '{8'h20, 8'hff, 8'h00, 5'b00000}};
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        chk_reset();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a, rv);
            chk("readback", rows[i].rb, rv);
            tick();
            chk("host_cfg", rows[i].hc, host_cfg_o);
        end
        // Both match modes over all four hit combinations
        for (int m = 0; m < 2; m++) begin
            wr(8'h05, 8'(m));
            for (int i = 0; i < 4; i++) begin
                @(posedge clk_sys_i);
                src_hit <= i[0];
                dst_hit <= i[1];
                tick();
                chk("mirror", (m == 1) ? (i == 3) : (i != 0), sniff_mirror_o);
            end
        end
        // Flush on port 1 only, read back while it runs
        wr(8'h08, 8'h81);
        rd(8'h08, rv);
        chk("flush_busy", 8'h81, rv);
        chk("mib_flush", 16'h0020, mib_ctl_o);
        n = 0;
        for (int i = 0; i < 20; i++) begin
            tick();
            if (mib_ctl_o.flush[0] === 1'b1) n++;
        end
        chk("flush_len", SGCR_FLUSH_CYC - 2, n);
        rd(8'h08, rv);
        chk("flush_done", 8'h01, rv);
        wr(8'h08, 8'h7f);
        rd(8'h08, rv);
        chk("freeze_reg", 8'h5f, rv);
        chk("mib_freeze", 16'h001f, mib_ctl_o);
        // Second reset in mid-run; it restarts the period timer, so storm timing is known
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        chk_reset();
        // Storm limit of two blocks, meter on port 1
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h02);
        @(posedge clk_sys_i);
        sof <= 5'h02;
        @(posedge clk_sys_i);
        sof <= 5'h00;
        #1 chk("storm_pass", 16'h0000, storm_drop_o);
        burst();
        chk("storm_drop", 16'h0001, storm_drop_o);
        n = 0;
        while (storm_drop_o !== 5'h00 && n < PER + 10) begin
            tick();
            n++;
        end
        chk("drop_clears", 1, n <= PER);
        // Same burst at 10 Mbps holds the drop for the long period
        wr(8'h06, 8'h10);
        burst();
        chk("storm_drop_10m", 16'h0001, storm_drop_o);
        n = 0;
        while (storm_drop_o !== 5'h00 && n < 10 * PER + 10) begin
            tick();
            n++;
        end
        chk("drop_clears_10m", 1, n > PER && n <= 10 * PER);
        tally_and_finish();
    end
endmodule
